// ### rtl/lcr_bank.sv
// Lane conditioning register bank: storage, read-back and lane control outputs
//
// Overview of operation
// - Top de-emphasis bit picks style, low seven bits hold level code.
// - De-emphasis value 0x01 gives no de-emphasis, 0.0 dB.
// - Values 0x88, 0x90, 0xA0 select -6, -9, -12 dB.
// - Idle threshold bits 3:2 de-assert level, bits 1:0 assert level.
// - Threshold codes map to 110/70, 150/110, 170/130, 190/150 mV.
// - Idle-auto bit 5 set means automatic idle detect, else bit 4 rules.
// - Manual idle bit 4 zero drives output, detect off; one mutes output.
// - Speed-auto bit 1 set means automatic rate detect, else bit 0 rules.
// - Manual speed bit 0 zero is 2.5 Gbps, one is 5.0 Gbps.
// - Equalizer bit 5 enables, bits 4:3 gain stage, bits 2:0 boost.
// - Equalizer value 0x20 bypasses equalization and is the reset default.
// - Swing codes 0x03/07/0F/1F give 600/800/1000/1200 mV.
// - Speed pin override hands speed control to the register settings.
`default_nettype none
module lcr_bank
  import lcr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire lcr_req_t       reg_req,
  output logic      [7:0]     reg_rdata,
  output logic                reg_rvalid,
  input  wire logic           speed_pin,
  input  wire logic           speed_pin_override,
  input  wire logic           rate_detect_fast,
  output logic                lane0_deemphasis_style,
  output logic      [6:0]     lane0_deemphasis_level,
  output logic      [7:0]     lane0_deemph_tenth_db,
  output logic                lane0_deemph_known,
  output logic                lane0_deemph_reserved,
  output logic      [7:0]     lane0_idle_deassert_mv,
  output logic      [7:0]     lane0_idle_assert_mv,
  output lcr_lane1_ctl_t      lane1_ctl,
  output logic                lane1_eq_enable,
  output logic      [1:0]     lane1_gain_stage_pick,
  output logic      [2:0]     lane1_boost_level_pick,
  output logic      [3:0]     lane1_eq_level,
  output logic                lane1_eq_preset,
  output logic      [10:0]    lane1_output_swing_mv,
  output logic                lane1_output_swing_known
);
  // ***********************************************************************
  // Storage
  // ***********************************************************************
  logic [7:0]     deemph_ff;
  logic [7:0]     squelch_ff;
  logic [7:0]     idlespd_ff;
  logic [7:0]     eq_ff;
  logic [7:0]     swing_ff;
  logic [7:0]     nxt_rdata;
  logic [7:0]     dec_tdb;
  logic           dec_de_known;
  logic           dec_de_rsvd;
  logic [3:0]     dec_eq_level;
  logic           dec_eq_preset;
  logic [10:0]    dec_swing_mv;
  logic           dec_swing_known;
  lcr_lane1_ctl_t nxt_lane1_ctl;

  // Mask off reserved bits so they always read back as zero
  function automatic logic [7:0] wr_val(input logic [7:0] data, input logic [7:0] mask);
    wr_val = data & mask;
  endfunction

  // Register writes; offsets outside the map are ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deemph_ff  <= LCR_RST_DEEMPH;
      squelch_ff <= LCR_RST_SQUELCH;
      idlespd_ff <= LCR_RST_IDLESPD;
      eq_ff      <= LCR_RST_EQ;
      swing_ff   <= LCR_RST_SWING;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        // Reserved 0xC0 is stored as written; flagged, not repaired
        LCR_OFS_DEEMPH:  deemph_ff  <= wr_val(reg_req.wdata, LCR_MSK_DEEMPH);
        LCR_OFS_SQUELCH: squelch_ff <= wr_val(reg_req.wdata, LCR_MSK_SQUELCH);
        LCR_OFS_IDLESPD: idlespd_ff <= wr_val(reg_req.wdata, LCR_MSK_IDLESPD);
        LCR_OFS_EQ:      eq_ff      <= wr_val(reg_req.wdata, LCR_MSK_EQ);
        LCR_OFS_SWING:   swing_ff   <= wr_val(reg_req.wdata, LCR_MSK_SWING);
        default: begin
        end
      endcase
    end
  end

  // ***********************************************************************
  // Read-back
  // ***********************************************************************
  always_comb begin
    case (reg_req.addr)
      LCR_OFS_DEEMPH:  nxt_rdata = deemph_ff;
      LCR_OFS_SQUELCH: nxt_rdata = squelch_ff;
      LCR_OFS_IDLESPD: nxt_rdata = idlespd_ff;
      LCR_OFS_EQ:      nxt_rdata = eq_ff;
      LCR_OFS_SWING:   nxt_rdata = swing_ff;
      default:         nxt_rdata = LCR_RD_UNMAPPED;
    endcase
  end

  // Read data is registered; a same-cycle write is seen on the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  // ***********************************************************************
  // Table decode
  // ***********************************************************************
  lcr_decode u_decode (
    .deemph_code     (deemph_ff),
    .eq_code         (eq_ff[5:0]),
    .swing_code      (swing_ff[5:0]),
    .deemph_tenth_db (dec_tdb),
    .deemph_known    (dec_de_known),
    .deemph_reserved (dec_de_rsvd),
    .eq_level        (dec_eq_level),
    .eq_preset       (dec_eq_preset),
    .swing_mv        (dec_swing_mv),
    .swing_known     (dec_swing_known)
  );

  // ***********************************************************************
  // Lane 1 idle and speed control
  // ***********************************************************************
  always_comb begin
    nxt_lane1_ctl           = '0;
    nxt_lane1_ctl.idle_auto = idlespd_ff[LCR_IDLE_AUTO_BIT];
    if (idlespd_ff[LCR_IDLE_AUTO_BIT]) begin
      // Automatic detect owns muting; detector must run
      nxt_lane1_ctl.signal_detect_en = 1'b1;
      nxt_lane1_ctl.output_mute      = 1'b0;
    end else begin
      nxt_lane1_ctl.signal_detect_en = 1'b0;
      nxt_lane1_ctl.output_mute      = idlespd_ff[LCR_IDLE_SEL_BIT];
    end
    // Without the override the pin decides and the register bits are dormant
    if (speed_pin_override) begin
      nxt_lane1_ctl.rate_auto = idlespd_ff[LCR_SPD_AUTO_BIT];
      if (idlespd_ff[LCR_SPD_AUTO_BIT]) begin
        nxt_lane1_ctl.rate_5g = rate_detect_fast;
      end else begin
        nxt_lane1_ctl.rate_5g = idlespd_ff[LCR_SPD_SEL_BIT];
      end
    end else begin
      nxt_lane1_ctl.rate_auto = 1'b0;
      nxt_lane1_ctl.rate_5g   = speed_pin;
    end
  end

  // ***********************************************************************
  // Registered analog settings
  // ***********************************************************************
  // One stage of delay keeps analog controls glitch free across decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane0_deemphasis_style   <= 1'b0;
      lane0_deemphasis_level   <= 7'h03;
      lane0_deemph_tenth_db    <= 8'h00;
      lane0_deemph_known       <= 1'b0;
      lane0_deemph_reserved    <= 1'b0;
      lane0_idle_deassert_mv   <= 8'h6E;
      lane0_idle_assert_mv     <= 8'h46;
      lane1_ctl                <= '0;
      lane1_eq_enable          <= 1'b1;
      lane1_gain_stage_pick    <= 2'h0;
      lane1_boost_level_pick   <= 3'h0;
      lane1_eq_level           <= 4'h0;
      lane1_eq_preset          <= 1'b1;
      lane1_output_swing_mv    <= 11'h258;
      lane1_output_swing_known <= 1'b1;
    end else begin
      lane0_deemphasis_style   <= deemph_ff[LCR_DE_STYLE_BIT];
      lane0_deemphasis_level   <= deemph_ff[LCR_DE_LVL_MSB:0];
      lane0_deemph_tenth_db    <= dec_tdb;
      lane0_deemph_known       <= dec_de_known;
      lane0_deemph_reserved    <= dec_de_rsvd;
      lane0_idle_deassert_mv   <= LCR_TH_DEA[squelch_ff[LCR_SQ_DEA_MSB:LCR_SQ_DEA_LSB]];
      lane0_idle_assert_mv     <= LCR_TH_AST[squelch_ff[LCR_SQ_AST_MSB:LCR_SQ_AST_LSB]];
      lane1_ctl                <= nxt_lane1_ctl;
      lane1_eq_enable          <= eq_ff[LCR_EQ_EN_BIT];
      lane1_gain_stage_pick    <= eq_ff[LCR_EQ_GAIN_MSB:LCR_EQ_GAIN_LSB];
      lane1_boost_level_pick   <= eq_ff[LCR_EQ_BOOST_MSB:0];
      lane1_eq_level           <= dec_eq_level;
      lane1_eq_preset          <= dec_eq_preset;
      lane1_output_swing_mv    <= dec_swing_mv;
      lane1_output_swing_known <= dec_swing_known;
    end
  end
endmodule
`default_nettype wire

// ### rtl/lcr_decode.sv
// Table decode of de-emphasis, equalizer and swing codes into analog settings
`default_nettype none
module lcr_decode
  import lcr_pkg::*;
(
  input  wire logic [7:0]  deemph_code,
  input  wire logic [5:0]  eq_code,
  input  wire logic [5:0]  swing_code,
  output logic      [7:0]  deemph_tenth_db,
  output logic             deemph_known,
  output logic             deemph_reserved,
  output logic      [3:0]  eq_level,
  output logic             eq_preset,
  output logic      [10:0] swing_mv,
  output logic             swing_known
);
  // ***********************************************************************
  // De-emphasis magnitude
  // ***********************************************************************
  always_comb begin
    deemph_known    = 1'b1;
    deemph_reserved = (deemph_code == LCR_DE_RSVD);
    case (deemph_code)
      LCR_DE_0DB:   deemph_tenth_db = LCR_TDB_0;
      LCR_DE_3P5DB: deemph_tenth_db = LCR_TDB_3P5;
      LCR_DE_6DB:   deemph_tenth_db = LCR_TDB_6;
      LCR_DE_9DB:   deemph_tenth_db = LCR_TDB_9;
      LCR_DE_12DB:  deemph_tenth_db = LCR_TDB_12;
      default: begin
        // Reserved or off-table codes give no defined level
        deemph_tenth_db = LCR_TDB_0;
        deemph_known    = 1'b0;
      end
    endcase
  end

  // ***********************************************************************
  // Equalizer preset rank, 0 is bypass
  // ***********************************************************************
  always_comb begin
    eq_preset = 1'b1;
    case (eq_code)
      LCR_EQ_BYPASS: eq_level = 4'h0;
      LCR_EQ_P1:     eq_level = 4'h1;
      LCR_EQ_P2:     eq_level = 4'h2;
      LCR_EQ_P3:     eq_level = 4'h3;
      LCR_EQ_P4:     eq_level = 4'h4;
      LCR_EQ_P5:     eq_level = 4'h5;
      LCR_EQ_P6:     eq_level = 4'h6;
      LCR_EQ_P7:     eq_level = 4'h7;
      LCR_EQ_P8:     eq_level = 4'h8;
      default: begin
        // Raw fields still drive the stages; only the rank is unknown
        eq_level  = 4'h0;
        eq_preset = 1'b0;
      end
    endcase
  end

  // ***********************************************************************
  // Output swing amplitude
  // ***********************************************************************
  always_comb begin
    swing_known = 1'b1;
    case (swing_code)
      LCR_SW_600:  swing_mv = LCR_MV_600;
      LCR_SW_800:  swing_mv = LCR_MV_800;
      LCR_SW_1000: swing_mv = LCR_MV_1000;
      LCR_SW_1200: swing_mv = LCR_MV_1200;
      default: begin
        swing_mv    = LCR_MV_600;
        swing_known = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/lcr_pkg.sv
// Package of offsets, field layouts, reset values and decode constants for the lane bank
`default_nettype none
package lcr_pkg;
  // ***********************************************************************
  // Register offsets
  // ***********************************************************************
  localparam logic [7:0] LCR_OFS_DEEMPH  = 8'h11;
  localparam logic [7:0] LCR_OFS_SQUELCH = 8'h12;
  localparam logic [7:0] LCR_OFS_IDLESPD = 8'h15;
  localparam logic [7:0] LCR_OFS_EQ      = 8'h16;
  localparam logic [7:0] LCR_OFS_SWING   = 8'h17;

  // ***********************************************************************
  // Reset values and writable masks (reserved bits read zero)
  // ***********************************************************************
  localparam logic [7:0] LCR_RST_DEEMPH  = 8'h03;
  localparam logic [7:0] LCR_RST_SQUELCH = 8'h00;
  localparam logic [7:0] LCR_RST_IDLESPD = 8'h00;
  localparam logic [7:0] LCR_RST_EQ      = 8'h20;
  localparam logic [7:0] LCR_RST_SWING   = 8'h03;
  localparam logic [7:0] LCR_MSK_DEEMPH  = 8'hFF;
  localparam logic [7:0] LCR_MSK_SQUELCH = 8'h0F;
  localparam logic [7:0] LCR_MSK_IDLESPD = 8'h33;
  localparam logic [7:0] LCR_MSK_EQ      = 8'h3F;
  localparam logic [7:0] LCR_MSK_SWING   = 8'h3F;
  localparam logic [7:0] LCR_RD_UNMAPPED = 8'h00;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int LCR_DE_STYLE_BIT  = 7;
  localparam int LCR_DE_LVL_MSB    = 6;
  localparam int LCR_SQ_DEA_MSB    = 3;
  localparam int LCR_SQ_DEA_LSB    = 2;
  localparam int LCR_SQ_AST_MSB    = 1;
  localparam int LCR_SQ_AST_LSB    = 0;
  localparam int LCR_IDLE_AUTO_BIT = 5;
  localparam int LCR_IDLE_SEL_BIT  = 4;
  localparam int LCR_SPD_AUTO_BIT  = 1;
  localparam int LCR_SPD_SEL_BIT   = 0;
  localparam int LCR_EQ_EN_BIT     = 5;
  localparam int LCR_EQ_GAIN_MSB   = 4;
  localparam int LCR_EQ_GAIN_LSB   = 3;
  localparam int LCR_EQ_BOOST_MSB  = 2;

  // ***********************************************************************
  // Decode tables: de-emphasis codes and magnitudes in tenths of a dB
  // ***********************************************************************
  localparam logic [7:0] LCR_DE_0DB    = 8'h01;
  localparam logic [7:0] LCR_DE_3P5DB  = 8'hE8;
  localparam logic [7:0] LCR_DE_6DB    = 8'h88;
  localparam logic [7:0] LCR_DE_9DB    = 8'h90;
  localparam logic [7:0] LCR_DE_12DB   = 8'hA0;
  localparam logic [7:0] LCR_DE_RSVD   = 8'hC0;
  localparam logic [7:0] LCR_TDB_0     = 8'h00;
  localparam logic [7:0] LCR_TDB_3P5   = 8'h23;
  localparam logic [7:0] LCR_TDB_6     = 8'h3C;
  localparam logic [7:0] LCR_TDB_9     = 8'h5A;
  localparam logic [7:0] LCR_TDB_12    = 8'h78;

  // Equalizer presets in increasing strength
  localparam logic [5:0] LCR_EQ_BYPASS = 6'h20;
  localparam logic [5:0] LCR_EQ_P1     = 6'h2A;
  localparam logic [5:0] LCR_EQ_P2     = 6'h30;
  localparam logic [5:0] LCR_EQ_P3     = 6'h32;
  localparam logic [5:0] LCR_EQ_P4     = 6'h35;
  localparam logic [5:0] LCR_EQ_P5     = 6'h37;
  localparam logic [5:0] LCR_EQ_P6     = 6'h39;
  localparam logic [5:0] LCR_EQ_P7     = 6'h3B;
  localparam logic [5:0] LCR_EQ_P8     = 6'h3D;

  // Output swing codes and amplitudes in mV
  localparam logic [5:0]  LCR_SW_600   = 6'h03;
  localparam logic [5:0]  LCR_SW_800   = 6'h07;
  localparam logic [5:0]  LCR_SW_1000  = 6'h0F;
  localparam logic [5:0]  LCR_SW_1200  = 6'h1F;
  localparam logic [10:0] LCR_MV_600   = 11'h258;
  localparam logic [10:0] LCR_MV_800   = 11'h320;
  localparam logic [10:0] LCR_MV_1000  = 11'h3E8;
  localparam logic [10:0] LCR_MV_1200  = 11'h4B0;

  // Idle thresholds in mV, indexed by two-bit code
  localparam logic [7:0] LCR_TH_DEA [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
  localparam logic [7:0] LCR_TH_AST [4] = '{8'h46, 8'h6E, 8'h82, 8'h96};

  // ***********************************************************************
  // Carriers
  // ***********************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_req_t;

  typedef struct packed {
    logic       idle_auto;
    logic       output_mute;
    logic       signal_detect_en;
    logic       rate_auto;
    logic       rate_5g;
  } lcr_lane1_ctl_t;
endpackage
`default_nettype wire

// ### test/lcr_bank_checker.sv
// Checker of lane bank register writes against the lane control outputs
`default_nettype none
module lcr_bank_checker
  import lcr_pkg::*;
(
  input wire logic           clk,
  input wire logic           nrst,
  input wire lcr_req_t       reg_req,
  input wire logic           speed_pin,
  input wire logic           speed_pin_override,
  input wire logic           rate_detect_fast,
  input wire logic           lane0_deemphasis_style,
  input wire logic [6:0]     lane0_deemphasis_level,
  input wire logic [7:0]     lane0_deemph_tenth_db,
  input wire logic           lane0_deemph_known,
  input wire logic [7:0]     lane0_idle_deassert_mv,
  input wire logic [7:0]     lane0_idle_assert_mv,
  input wire lcr_lane1_ctl_t lane1_ctl,
  input wire logic           lane1_eq_enable,
  input wire logic [1:0]     lane1_gain_stage_pick,
  input wire logic [2:0]     lane1_boost_level_pick,
  input wire logic [3:0]     lane1_eq_level,
  input wire logic [10:0]    lane1_output_swing_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ***********************************************************************
  // Expected decodes, written out from the code tables
  // ***********************************************************************
  function automatic logic [7:0] tdb(logic [7:0] d);
    return (d == 8'h88) ? 8'h3C : (d == 8'h90) ? 8'h5A : (d == 8'hA0) ? 8'h78 : 8'h00;
  endfunction
  // Assert level sits 40 mV under de-assert for every code
  function automatic logic [7:0] th(logic [1:0] c);
    return (c == 2'h0) ? 8'h6E : (c == 2'h1) ? 8'h96 : (c == 2'h2) ? 8'hAA : 8'hBE;
  endfunction
  function automatic logic [15:0] sq(logic [7:0] d);
    return {th(d[3:2]), th(d[1:0]) - 8'h28};
  endfunction
  function automatic logic [2:0] idl(logic [7:0] d);
    return d[5] ? 3'h5 : {1'b0, d[4], 1'b0};
  endfunction
  function automatic logic [1:0] spd(logic [7:0] d, logic f);
    return {d[1], d[1] ? f : d[0]};
  endfunction
  function automatic logic [3:0] rank(logic [7:0] d);
    logic [7:0] p [9];
    p = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h35, 8'h37, 8'h39, 8'h3B, 8'h3D};
    for (int i = 0; i < 9; i++) if (p[i] == d) return 4'(i);
    return 4'h0;
  endfunction
  function automatic logic [10:0] mv(logic [7:0] d);
    return (d == 8'h03) ? 11'h258 : (d == 8'h07) ? 11'h320 : (d == 8'h0F) ? 11'h3E8 : 11'h4B0;
  endfunction
  // ***********************************************************************
  // Write to one offset; outputs follow two edges later
  // ***********************************************************************
  sequence s_wr(logic [7:0] ofs);
    reg_req.wr && reg_req.addr == ofs;
  endsequence
  property p_de_fields;
    s_wr(LCR_OFS_DEEMPH) |-> ##2
      {lane0_deemphasis_style, lane0_deemphasis_level} == $past(reg_req.wdata, 2);
  endproperty
  a_de_fields: assert property (p_de_fields) else $error("de-emphasis fields wrong");
  property p_de_db;
    s_wr(LCR_OFS_DEEMPH) ##0 reg_req.wdata inside {8'h01, 8'h88, 8'h90, 8'hA0} |-> ##2
      lane0_deemph_known && lane0_deemph_tenth_db == tdb($past(reg_req.wdata, 2));
  endproperty
  a_de_db: assert property (p_de_db) else $error("de-emphasis level wrong");
  property p_sq;
    s_wr(LCR_OFS_SQUELCH) |-> ##2
      {lane0_idle_deassert_mv, lane0_idle_assert_mv} == sq($past(reg_req.wdata, 2));
  endproperty
  a_sq: assert property (p_sq) else $error("idle thresholds wrong");
  property p_idle;
    s_wr(LCR_OFS_IDLESPD) |-> ##2 lane1_ctl[4:2] == idl($past(reg_req.wdata, 2));
  endproperty
  a_idle: assert property (p_idle) else $error("idle control wrong");
  // Override held means the pin is ignored
  property p_spd;
    s_wr(LCR_OFS_IDLESPD) ##1 speed_pin_override |=>
      lane1_ctl[1:0] == spd($past(reg_req.wdata, 2), $past(rate_detect_fast));
  endproperty
  a_spd: assert property (p_spd) else $error("register speed control wrong");
  property p_pin;
    !speed_pin_override |=> lane1_ctl[1:0] == {1'b0, $past(speed_pin)};
  endproperty
  a_pin: assert property (p_pin) else $error("pin speed control wrong");
  property p_eq_fields;
    s_wr(LCR_OFS_EQ) ##0 reg_req.wdata[7:6] == 2'h0 |-> ##2 {2'h0, lane1_eq_enable,
      lane1_gain_stage_pick, lane1_boost_level_pick} == $past(reg_req.wdata, 2);
  endproperty
  a_eq_fields: assert property (p_eq_fields) else $error("equalizer fields wrong");
  property p_eq_rank;
    s_wr(LCR_OFS_EQ) ##0 rank(reg_req.wdata) != 4'h0 |-> ##2
      lane1_eq_level == rank($past(reg_req.wdata, 2));
  endproperty
  a_eq_rank: assert property (p_eq_rank) else $error("equalizer level wrong");
  property p_swing;
    s_wr(LCR_OFS_SWING) ##0 reg_req.wdata inside {8'h03, 8'h07, 8'h0F, 8'h1F} |-> ##2
      lane1_output_swing_mv == mv($past(reg_req.wdata, 2));
  endproperty
  a_swing: assert property (p_swing) else $error("output swing wrong");
endmodule
bind lcr_bank lcr_bank_checker u_lcr_bank_checker (.clk(clk), .nrst(nrst), .reg_req(reg_req),
  .speed_pin(speed_pin), .speed_pin_override(speed_pin_override),
  .rate_detect_fast(rate_detect_fast), .lane0_deemphasis_style(lane0_deemphasis_style),
  .lane0_deemphasis_level(lane0_deemphasis_level), .lane0_deemph_known(lane0_deemph_known),
  .lane0_deemph_tenth_db(lane0_deemph_tenth_db), .lane0_idle_assert_mv(lane0_idle_assert_mv),
  .lane0_idle_deassert_mv(lane0_idle_deassert_mv), .lane1_ctl(lane1_ctl),
  .lane1_eq_enable(lane1_eq_enable), .lane1_gain_stage_pick(lane1_gain_stage_pick),
  .lane1_boost_level_pick(lane1_boost_level_pick), .lane1_eq_level(lane1_eq_level),
  .lane1_output_swing_mv(lane1_output_swing_mv));
`default_nettype wire

// ### test/lcr_bank_test.sv
// Self-checking bench of the lane conditioning register bank
`default_nettype none
module lcr_bank_test;
  import lcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk, nrst, speed_pin, speed_pin_override, rate_detect_fast;
  lcr_req_t       reg_req;
  logic [7:0]     reg_rdata, tdb, dea_mv, ast_mv;
  logic           reg_rvalid, style, known, rsvd, eq_en, eq_pre, sw_known;
  logic [6:0]     level;
  lcr_lane1_ctl_t lane1_ctl;
  logic [1:0]     gain_pick;
  logic [2:0]     boost_pick;
  logic [3:0]     eq_lvl;
  logic [10:0]    sw_mv;
  int             errors, n_checks;
  logic [7:0]     ofs [6] = '{8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h13};
  logic [7:0]     rstv [6] = '{8'h03, 8'h00, 8'h00, 8'h20, 8'h03, 8'h00};
  logic [7:0]     dcode [5] = '{8'h01, 8'h88, 8'h90, 8'hA0, 8'hE8};
  logic [7:0]     dtdb [5] = '{8'h00, 8'h3C, 8'h5A, 8'h78, 8'h23};
  logic [7:0]     sqd [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
  logic [7:0]     sqa [4] = '{8'h46, 8'h82, 8'h6E, 8'h96};
  logic [7:0]     sqc [4] = '{8'h00, 8'h06, 8'h09, 8'h0F};
  logic [7:0]     isc [5] = '{8'h00, 8'h10, 8'h20, 8'h01, 8'h02};
  logic [4:0]     ise [5] = '{5'h00, 5'h08, 5'h14, 5'h01, 5'h03};
  logic [7:0]     eqc [9] = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h35, 8'h37, 8'h39, 8'h3B, 8'h3D};
  logic [7:0]     swc [4] = '{8'h03, 8'h07, 8'h0F, 8'h1F};
  logic [10:0]    swm [4] = '{11'h258, 11'h320, 11'h3E8, 11'h4B0};
  lcr_host u_lcr_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  lcr_bank u_lcr_bank (.clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .speed_pin(speed_pin), .speed_pin_override(speed_pin_override),
    .rate_detect_fast(rate_detect_fast), .lane0_deemphasis_style(style),
    .lane0_deemphasis_level(level), .lane0_deemph_tenth_db(tdb), .lane0_deemph_known(known),
    .lane0_deemph_reserved(rsvd), .lane0_idle_deassert_mv(dea_mv),
    .lane0_idle_assert_mv(ast_mv), .lane1_ctl(lane1_ctl), .lane1_eq_enable(eq_en),
    .lane1_gain_stage_pick(gain_pick), .lane1_boost_level_pick(boost_pick),
    .lane1_eq_level(eq_lvl),
    .lane1_eq_preset(eq_pre), .lane1_output_swing_mv(sw_mv), .lane1_output_swing_known(sw_known));
  // ***********************************************************************
  // Clock, checks and closing report
  // ***********************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A missing read strobe forces a mismatch
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_lcr_host.read_reg(a, d, ok);
    if (ok !== 1'b1) d = ~exp;
    chk_out({3'h0, d}, {3'h0, exp});
  endtask
  // Outputs settle one edge after the write is stored
  task automatic wr_set(input logic [7:0] a, input logic [7:0] d);
    u_lcr_host.write_reg(a, d);
    @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    {nrst, speed_pin, speed_pin_override, rate_detect_fast} = 4'b0011;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 6; i++) chk_reg(ofs[i], rstv[i]);
    chk_out({7'h0, eq_lvl}, 11'h000);
    chk_out(sw_mv, 11'h258);
    chk_out({9'h0, known, rsvd}, 11'h000);
    chk_out({9'h0, eq_pre, sw_known}, 11'h003);
    for (int i = 0; i < 5; i++) begin
      wr_set(8'h11, dcode[i]);
      chk_out({3'h0, tdb}, {3'h0, dtdb[i]});
      chk_out({9'h0, known, rsvd}, 11'h002);
      chk_out({3'h0, style, level}, {3'h0, dcode[i]});
      chk_reg(8'h11, dcode[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_set(8'h12, sqc[i]);
      chk_out({3'h0, dea_mv}, {3'h0, sqd[i]});
      chk_out({3'h0, ast_mv}, {3'h0, sqa[i]});
    end
    for (int i = 0; i < 5; i++) begin
      wr_set(8'h15, isc[i]);
      chk_out({6'h0, lane1_ctl}, {6'h0, ise[i]});
    end
    // Detector result followed only while rate auto is set
    rate_detect_fast = 1'b0;
    @(posedge clk);
    #1 chk_out({6'h0, lane1_ctl}, 11'h002);
    speed_pin_override = 1'b0;
    speed_pin = 1'b1;
    @(posedge clk);
    #1 chk_out({6'h0, lane1_ctl}, 11'h001);
    for (int i = 0; i < 9; i++) begin
      wr_set(8'h16, eqc[i]);
      chk_out({7'h0, eq_lvl}, 11'(i));
      chk_out({5'h0, eq_en, gain_pick, boost_pick}, {3'h0, eqc[i]});
      chk_out({10'h0, eq_pre}, 11'h001);
    end
    // Off-table equalizer code keeps raw fields but loses its rank
    wr_set(8'h16, 8'h21);
    chk_out({6'h0, eq_lvl, eq_pre}, 11'h000);
    chk_out({5'h0, eq_en, gain_pick, boost_pick}, 11'h021);
    for (int i = 0; i < 4; i++) begin
      wr_set(8'h17, swc[i]);
      chk_out(sw_mv, swm[i]);
      chk_out({10'h0, sw_known}, 11'h001);
    end
    // Off-table swing code is flagged as unknown
    wr_set(8'h17, 8'h01);
    chk_out({10'h0, sw_known}, 11'h000);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### test/lcr_host.sv
// Host model issuing single-byte register requests to the lane bank
`default_nettype none
module lcr_host
  import lcr_pkg::*;
(
  input  wire logic       clk,
  output var  lcr_req_t   reg_req,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;
  // Request held across exactly one taken edge; callers also pass off-table codes such as 0x21 and 0x01
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 reg_req = '0;
  endtask
  // Answer has fixed one-cycle latency, so no open wait is needed
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 reg_req = '0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire
